//--- mnsc_pkg.sv
// Package: constants and types for the instruction execution block
package mnsc_pkg;
    // ****************************************************************
    // Register map (AXI4-Lite byte addresses)
    // ****************************************************************
    localparam logic [7:0] MNSC_OFF_INSTR   = 8'h00;
    localparam logic [7:0] MNSC_OFF_ACCUM   = 8'h04;
    localparam logic [7:0] MNSC_OFF_BANK    = 8'h08;
    localparam logic [7:0] MNSC_OFF_PC      = 8'h0c;
    localparam logic [7:0] MNSC_OFF_PROD    = 8'h10;
    localparam logic [7:0] MNSC_OFF_STATUS  = 8'h14;
    localparam logic [7:0] MNSC_OFF_TOP     = 8'h18;
    localparam logic [7:0] MNSC_OFF_DEPTH   = 8'h1c;
    localparam logic [7:0] MNSC_OFF_MEMWIN  = 8'h20;
    localparam logic [7:0] MNSC_OFF_MEMDATA = 8'h24;
    // ****************************************************************
    // Status flag positions
    // ****************************************************************
    localparam int MNSC_FLAG_CARRY  = 0;
    localparam int MNSC_FLAG_NIBBLE = 1;
    localparam int MNSC_FLAG_ZERO   = 2;
    localparam int MNSC_FLAG_WRAP   = 3;
    localparam int MNSC_FLAG_MSB    = 4;
    // ****************************************************************
    // Reset values and counts
    // ****************************************************************
    localparam logic [20:0] MNSC_PC_RST    = 21'h000000;
    localparam logic [1:0]  MNSC_Q_LAST    = 2'h3;
    localparam logic [1:0]  MNSC_Q_POP     = 2'h2;
    localparam logic [7:0]  MNSC_ACCESS_SPLIT = 8'h80;
    localparam logic [3:0]  MNSC_ACCESS_HIGH_BANK = 4'hf;
    localparam logic [1:0]  MNSC_RESP_OKAY = 2'h0;
    localparam logic [1:0]  MNSC_RESP_SLVERR = 2'h2;
    // ****************************************************************
    // Opcode patterns
    // ****************************************************************
    localparam logic [6:0]  MNSC_OP_MULF   = 7'h01;
    localparam logic [6:0]  MNSC_OP_NEG    = 7'h36;
    localparam logic [15:0] MNSC_OP_IDLE   = 16'h0000;
    localparam logic [15:0] MNSC_OP_POP    = 16'h0006;
    localparam logic [15:0] MNSC_OP_PUSH   = 16'h0005;
    localparam logic [4:0]  MNSC_OP_CALL   = 5'h1b;
    localparam logic [3:0]  MNSC_OP_IDLE2  = 4'hf;

    typedef enum {
        MNSC_IDLE,
        MNSC_RUN,
        MNSC_FLUSH
    } mnsc_state_t;
endpackage : mnsc_pkg

//--- mnsc_stack.sv
// Return stack: push, pop and top-of-stack view
`timescale 1ns/1ps
`default_nettype none
module mnsc_stack
    import mnsc_pkg::*;
#(
    parameter int DEPTH = 31,
    parameter int AW    = 21
) (
    // Clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // Operations
    input  wire logic          push,
    input  wire logic          pop,
    input  wire logic [AW-1:0] push_value,
    // View
    output logic [AW-1:0]      top,
    output logic [4:0]         depth
);
    logic [AW-1:0] entry_reg [DEPTH];
    logic [4:0]    depth_reg;

    // Push shifts down, pop shifts up; overflow drops the deepest entry
    always_ff @(posedge aclk) begin
        if (push) begin
            entry_reg[0] <= push_value;
        end else if (pop) begin
            entry_reg[0] <= entry_reg[1];
        end
    end

    genvar gi;
    for (gi = 1; gi < DEPTH; gi++) begin : g_lvl
        always_ff @(posedge aclk) begin
            if (push) begin
                entry_reg[gi] <= entry_reg[gi-1];
            end else if (pop) begin
                entry_reg[gi] <= (gi == DEPTH - 1) ? '0 : entry_reg[(gi+1)%DEPTH];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            depth_reg <= 5'h00;
        end else if (push && depth_reg != 5'(DEPTH)) begin
            depth_reg <= depth_reg + 5'h01;
        end else if (pop && depth_reg != 5'h00) begin
            depth_reg <= depth_reg - 5'h01;
        end
    end

    assign top   = entry_reg[0];
    assign depth = depth_reg;
endmodule // mnsc_stack
`default_nettype wire

//--- mnsc_core.sv
// Execution core for multiply, negate, idle, stack and relative call opcodes
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module mnsc_core
    import mnsc_pkg::*;
#(
    parameter int STACK_DEPTH = 31,
    parameter int MEM_DEPTH   = 4096
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Execution status
    output logic             busy
);
    // ****************************************************************
    // State
    // ****************************************************************
    logic [7:0]  mem_reg [MEM_DEPTH];
    logic [7:0]  accum_reg;
    logic [3:0]  bank_pointer_reg;
    logic [20:0] pc_reg;
    logic [7:0]  product_high_byte_reg;
    logic [7:0]  product_low_byte_reg;
    logic [4:0]  status_reg;
    logic [15:0] instr_reg;
    logic [11:0] memwin_reg;
    logic [1:0]  phase_reg;
    mnsc_state_t state_reg;
    logic        busy_reg;
    logic        awdone_reg, wdone_reg, bvalid_reg, rvalid_reg;
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg, rdata_reg;
    logic [1:0]  bresp_reg, rresp_reg;

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire        op_a        = instr_reg[8];
    wire [7:0]  op_f        = instr_reg[7:0];
    wire        is_mulf     = instr_reg[15:9] == MNSC_OP_MULF;
    wire        is_neg      = instr_reg[15:9] == MNSC_OP_NEG;
    wire        is_pop      = instr_reg == MNSC_OP_POP;
    wire        is_push     = instr_reg == MNSC_OP_PUSH;
    wire        is_call     = instr_reg[15:11] == MNSC_OP_CALL;
    // Access bank: low half of bank 0, high half of the top bank
    wire [3:0]  access_bank = (op_f < MNSC_ACCESS_SPLIT) ? 4'h0 : MNSC_ACCESS_HIGH_BANK;
    wire [3:0]  sel_bank    = op_a ? bank_pointer_reg : access_bank;
    wire [11:0] mem_addr    = {sel_bank, op_f};
    wire [7:0]  operand     = mem_reg[mem_addr];
    wire [15:0] product     = accum_reg * operand;
    wire [7:0]  neg_val     = 8'h00 - operand;
    wire [8:0]  neg_sum     = {1'b0, ~operand} + 9'h001;
    wire [4:0]  neg_nib     = {1'b0, ~operand[3:0]} + 5'h01;
    wire        neg_wrap    = operand == 8'h80;
    wire [20:0] pc_inc      = pc_reg + 21'h000002;
    wire [20:0] rel_off     = {{9{instr_reg[10]}}, instr_reg[10:0], 1'b0};
    wire [20:0] call_tgt    = pc_inc + rel_off;
    wire        in_run      = state_reg == MNSC_RUN;
    // Push happens at the second phase, pop at the third
    wire        do_push     = in_run && phase_reg == 2'h1 && (is_push || is_call);
    wire        do_pop      = in_run && phase_reg == MNSC_Q_POP && is_pop;
    wire        last_q      = phase_reg == MNSC_Q_LAST;
    wire        do_write    = in_run && last_q;
    wire [20:0] stack_top;
    wire [4:0]  stack_depth;

    // ****************************************************************
    // Return stack
    // ****************************************************************
    mnsc_stack #(
        .DEPTH (STACK_DEPTH),
        .AW    (21)
    ) u_stack (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .push       (do_push),
        .pop        (do_pop),
        .push_value (pc_inc),
        .top        (stack_top),
        .depth      (stack_depth)
    );

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    wire aw_take   = s_axi_awvalid && !awdone_reg;
    wire w_take    = s_axi_wvalid && !wdone_reg;
    // A half is captured only while its ready is shown to the master
    wire aw_acc    = aw_take && !busy_reg && !bvalid_reg;
    wire w_acc     = w_take && !busy_reg && !bvalid_reg;
    wire [7:0]  aw_a = aw_take ? s_axi_awaddr : awaddr_reg;
    wire [31:0] w_d  = w_take ? s_axi_wdata : wdata_reg;
    wire have_aw   = awdone_reg || aw_take;
    wire have_w    = wdone_reg || w_take;
    // Writes wait while executing so software never races the core
    wire wr_fire   = have_aw && have_w && !bvalid_reg && !busy_reg;
    wire wr_instr  = wr_fire && aw_a == MNSC_OFF_INSTR;
    wire wr_accum  = wr_fire && aw_a == MNSC_OFF_ACCUM;
    wire wr_bank   = wr_fire && aw_a == MNSC_OFF_BANK;
    wire wr_pc     = wr_fire && aw_a == MNSC_OFF_PC;
    wire wr_win    = wr_fire && aw_a == MNSC_OFF_MEMWIN;
    wire wr_mem    = wr_fire && aw_a == MNSC_OFF_MEMDATA;
    wire wr_known  = wr_instr || wr_accum || wr_bank || wr_pc || wr_win || wr_mem;
    wire rd_take   = s_axi_arvalid && !rvalid_reg;
    wire [31:0] rd_mux =
        (s_axi_araddr == MNSC_OFF_INSTR)   ? {16'h0000, instr_reg} :
        (s_axi_araddr == MNSC_OFF_ACCUM)   ? {24'h000000, accum_reg} :
        (s_axi_araddr == MNSC_OFF_BANK)    ? {28'h0000000, bank_pointer_reg} :
        (s_axi_araddr == MNSC_OFF_PC)      ? {11'h000, pc_reg} :
        (s_axi_araddr == MNSC_OFF_PROD)    ? {16'h0000, product_high_byte_reg,
                                              product_low_byte_reg} :
        (s_axi_araddr == MNSC_OFF_STATUS)  ? {26'h0000000, busy_reg, status_reg} :
        (s_axi_araddr == MNSC_OFF_TOP)     ? {11'h000, stack_top} :
        (s_axi_araddr == MNSC_OFF_DEPTH)   ? {27'h0000000, stack_depth} :
        (s_axi_araddr == MNSC_OFF_MEMWIN)  ? {20'h00000, memwin_reg} :
        (s_axi_araddr == MNSC_OFF_MEMDATA) ? {24'h000000, mem_reg[memwin_reg]} :
                                             32'h00000000;
    wire rd_known  = s_axi_araddr <= MNSC_OFF_MEMDATA && s_axi_araddr[1:0] == 2'h0;

    // ****************************************************************
    // AXI4-Lite channels
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awdone_reg <= 1'b0;
            wdone_reg  <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg  <= 32'h00000000;
            bvalid_reg <= 1'b0;
            bresp_reg  <= MNSC_RESP_OKAY;
        end else begin
            if (wr_fire) begin
                awdone_reg <= 1'b0;
                wdone_reg  <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_known ? MNSC_RESP_OKAY : MNSC_RESP_SLVERR;
            end else begin
                if (aw_acc) begin
                    awdone_reg <= 1'b1;
                    awaddr_reg <= s_axi_awaddr;
                end
                if (w_acc) begin
                    wdone_reg <= 1'b1;
                    wdata_reg <= s_axi_wdata;
                end
                if (bvalid_reg && s_axi_bready) begin
                    bvalid_reg <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= MNSC_RESP_OKAY;
        end else if (rd_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_mux;
            rresp_reg  <= rd_known ? MNSC_RESP_OKAY : MNSC_RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // Sequencer: four phases per cycle
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= MNSC_IDLE;
            phase_reg <= 2'h0;
            busy_reg  <= 1'b0;
            instr_reg <= MNSC_OP_IDLE;
        end else begin
            phase_reg <= (state_reg == MNSC_IDLE) ? 2'h0 : phase_reg + 2'h1;
            case (state_reg)
                MNSC_IDLE: begin
                    if (wr_instr) begin
                        instr_reg <= w_d[15:0];
                        state_reg <= MNSC_RUN;
                        busy_reg  <= 1'b1;
                    end
                end
                MNSC_RUN: begin
                    if (last_q) begin
                        state_reg <= is_call ? MNSC_FLUSH : MNSC_IDLE;
                        busy_reg  <= is_call;
                    end
                end
                MNSC_FLUSH: begin
                    // Second call cycle: refetch slot, nothing happens
                    if (last_q) begin
                        state_reg <= MNSC_IDLE;
                        busy_reg  <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= MNSC_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Architectural registers: bus writes while idle, opcode results in the fourth phase
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            accum_reg             <= 8'h00;
            bank_pointer_reg      <= 4'h0;
            pc_reg                <= MNSC_PC_RST;
            product_high_byte_reg <= 8'h00;
            product_low_byte_reg  <= 8'h00;
            status_reg            <= 5'h00;
            memwin_reg            <= 12'h000;
        end else begin
            if (wr_accum) accum_reg <= w_d[7:0];
            if (wr_bank)  bank_pointer_reg <= w_d[3:0];
            if (wr_win)   memwin_reg <= w_d[11:0];
            if (wr_pc) begin
                pc_reg <= w_d[20:0];
            end else if (do_write) begin
                // Idle and unknown opcodes just advance; flags untouched
                pc_reg <= is_call ? call_tgt : pc_inc;
            end
            if (do_write && is_mulf) begin
                product_high_byte_reg <= product[15:8];
                product_low_byte_reg  <= product[7:0];
            end
            if (do_write && is_neg) begin
                status_reg[MNSC_FLAG_CARRY]  <= neg_sum[8];
                status_reg[MNSC_FLAG_NIBBLE] <= neg_nib[4];
                status_reg[MNSC_FLAG_ZERO]   <= neg_val == 8'h00;
                status_reg[MNSC_FLAG_WRAP]   <= neg_wrap;
                status_reg[MNSC_FLAG_MSB]    <= neg_val[7];
            end
        end
    end

    // Data memory: no reset, large array
    always_ff @(posedge aclk) begin
        if (do_write && is_neg) begin
            mem_reg[mem_addr] <= neg_val;
        end else if (wr_mem && s_axi_wstrb[0]) begin
            mem_reg[memwin_reg] <= w_d[7:0];
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign s_axi_awready = aw_acc;
    assign s_axi_wready  = w_acc;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = rd_take;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign busy          = busy_reg;
endmodule // mnsc_core
`default_nettype wire

//--- mnsc_core_monitor.sv
// Checker for bus handshakes and execution timing of the core
`timescale 1ns/1ps
`default_nettype none
module mnsc_core_monitor
    import mnsc_pkg::*;
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Write channels
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // Read channels
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Status
    input wire logic        busy
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Only both halves in one cycle count; the bench always offers them together
    wire logic wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire logic rd_go = s_axi_arvalid && s_axi_arready;
    wire logic op_go = wr_go && (s_axi_awaddr == MNSC_OFF_INSTR);
    wire logic is_call = (s_axi_wdata[15:11] == MNSC_OP_CALL);

    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    wr_answer_a: assert property (wr_go |=> s_axi_bvalid) else $error("write not answered");
    rd_answer_a: assert property (rd_go |=> s_axi_rvalid) else $error("read not answered");
    rd_single_a: assert property (s_axi_arready |-> !s_axi_rvalid) else $error("second read");
    busy_stall_a: assert property (busy |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    rd_unmapped_a: assert property (rd_go && s_axi_araddr > MNSC_OFF_MEMDATA
        |=> s_axi_rresp == MNSC_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read");
    wr_unmapped_a: assert property (wr_go && s_axi_awaddr > MNSC_OFF_MEMDATA
        |=> s_axi_bresp == MNSC_RESP_SLVERR) else $error("bad write accepted");
    reset_quiet_a: assert property ($rose(aresetn) |-> !busy && !s_axi_bvalid && !s_axi_rvalid)
        else $error("activity after reset");
    call_cycles_a: assert property (op_go && is_call |=> busy [*8] ##1 !busy)
        else $error("call length wrong");
    op_cycles_a: assert property (op_go && !is_call |=> busy [*4] ##1 !busy)
        else $error("single cycle length wrong");
endmodule // mnsc_core_monitor
`default_nettype wire

//--- mnsc_core_bench.sv
// Self-checking bench for the execution core
`timescale 1ns/1ps
`default_nettype none
module mnsc_core_bench import mnsc_pkg::*;;
    // ****
    // Signals
    // ****
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, busy;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, st, v;
    logic        slow_answer = 1'b0;
    int          num_errors = 0, tests_run = 0, cycles = 0;

    always #20 aclk = ~aclk;
    mnsc_core u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .busy(busy));

    // ****
    // Bus and compare tasks
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Ready is looked at mid-cycle, so the release lands right after the taking edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_hs, w_hs, b_hs, bv;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= !slow_answer;
        b_hs = 1'b0;
        while (!b_hs) begin
            @(negedge aclk);
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            bv = bvalid;
            b_hs = bvalid && bready;
            if (b_hs) chk(32'(bresp), 32'(er));
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            bready <= !b_hs && (bready || bv);
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        logic ar_hs, r_hs, rv;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= !slow_answer;
        r_hs = 1'b0;
        while (!r_hs) begin
            @(negedge aclk);
            ar_hs = arvalid && arready;
            rv = rvalid;
            r_hs = rvalid && rready;
            d = rdata;
            if (r_hs) chk(32'(rresp), 32'(er));
            @(posedge aclk);
            if (ar_hs) arvalid <= 1'b0;
            rready <= !r_hs && (rready || rv);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d, MNSC_RESP_OKAY);
        chk(d, e);
    endtask
    task automatic ex(input logic [15:0] op);
        wr(MNSC_OFF_INSTR, 32'(op), MNSC_RESP_OKAY);
        do @(negedge aclk); while (busy !== 1'b0);
    endtask
    task automatic mset(input logic [11:0] a, input logic [7:0] d);
        wr(MNSC_OFF_MEMWIN, 32'(a), MNSC_RESP_OKAY);
        wr(MNSC_OFF_MEMDATA, 32'(d), MNSC_RESP_OKAY);
    endtask
    task automatic mchk(input logic [11:0] a, input logic [7:0] e);
        wr(MNSC_OFF_MEMWIN, 32'(a), MNSC_RESP_OKAY);
        rc(MNSC_OFF_MEMDATA, 32'(e));
    endtask
    function automatic logic [31:0] neg_st(input logic [7:0] x);
        logic [7:0]  r;
        logic [31:0] s;
        r = 8'h00 - x;
        s = 32'h0;
        s[MNSC_FLAG_CARRY] = (x == 8'h00);
        s[MNSC_FLAG_NIBBLE] = (x[3:0] == 4'h0);
        s[MNSC_FLAG_ZERO] = (r == 8'h00);
        s[MNSC_FLAG_WRAP] = (x == 8'h80);
        s[MNSC_FLAG_MSB] = r[7];
        return s;
    endfunction

    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        rc(MNSC_OFF_STATUS, 32'h0);
        rc(MNSC_OFF_DEPTH, 32'h0);
        rc(MNSC_OFF_PC, 32'h0);
        rd(8'h28, v, MNSC_RESP_SLVERR);
        chk(v, 32'h0);
        wr(8'h40, 32'h1234, MNSC_RESP_SLVERR);
        // Late answer acceptance makes the slave hold its response
        slow_answer = 1'b1;
        wr(MNSC_OFF_ACCUM, 32'h5a, MNSC_RESP_OKAY);
        rc(MNSC_OFF_ACCUM, 32'h5a);
        slow_answer = 1'b0;
        mset(12'h123, 8'h5a);
        wstrb <= 4'h0;
        mset(12'h123, 8'ha5);
        wstrb <= 4'hf;
        mchk(12'h123, 8'h5a);
    endtask
    task automatic t_negate();
        logic [7:0] xs [4];
        xs = '{8'h80, 8'h3a, 8'h00, 8'h01};
        wr(MNSC_OFF_BANK, 32'h2, MNSC_RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            mset(12'h290, 8'h55);
            mset(12'hf90, xs[i]);
            ex(16'h6c90);
            mchk(12'hf90, 8'h00 - xs[i]);
            rc(MNSC_OFF_STATUS, neg_st(xs[i]));
            mchk(12'h290, 8'h55);
        end
        mset(12'h010, 8'h01);
        ex(16'h6c10);
        mchk(12'h010, 8'hff);
        mset(12'h23a, 8'h3a);
        ex(16'h6d3a);
        mchk(12'h23a, 8'hc6);
    endtask
    task automatic t_mul();
        wr(MNSC_OFF_ACCUM, 32'hc4, MNSC_RESP_OKAY);
        mset(12'h244, 8'hb5);
        rd(MNSC_OFF_STATUS, st, MNSC_RESP_OKAY);
        ex(16'h0344);
        rc(MNSC_OFF_PROD, 32'hc4 * 32'hb5);
        rc(MNSC_OFF_ACCUM, 32'hc4);
        mchk(12'h244, 8'hb5);
        rc(MNSC_OFF_STATUS, st);
        wr(MNSC_OFF_ACCUM, 32'hff, MNSC_RESP_OKAY);
        mset(12'hfff, 8'hff);
        ex(16'h02ff);
        rc(MNSC_OFF_PROD, 32'hff * 32'hff);
    endtask
    task automatic t_idle();
        wr(MNSC_OFF_PC, 32'h100, MNSC_RESP_OKAY);
        ex(MNSC_OP_IDLE);
        ex(16'hf123);
        rc(MNSC_OFF_PC, 32'h104);
        rc(MNSC_OFF_STATUS, st);
        rc(MNSC_OFF_PROD, 32'hff * 32'hff);
        rc(MNSC_OFF_DEPTH, 32'h0);
    endtask
    task automatic t_stack();
        wr(MNSC_OFF_PC, 32'h124, MNSC_RESP_OKAY);
        ex(MNSC_OP_PUSH);
        rc(MNSC_OFF_TOP, 32'h126);
        wr(MNSC_OFF_PC, 32'h3458, MNSC_RESP_OKAY);
        ex(MNSC_OP_PUSH);
        rc(MNSC_OFF_TOP, 32'h345a);
        rc(MNSC_OFF_DEPTH, 32'h2);
        ex(MNSC_OP_POP);
        rc(MNSC_OFF_TOP, 32'h126);
        rc(MNSC_OFF_DEPTH, 32'h1);
        rc(MNSC_OFF_STATUS, st);
    endtask
    task automatic t_call();
        wr(MNSC_OFF_PC, 32'h1000, MNSC_RESP_OKAY);
        ex(16'hdc00);
        rc(MNSC_OFF_PC, 32'h1000 + 32'h2 - 32'h800);
        rc(MNSC_OFF_TOP, 32'h1002);
        ex(16'hdbff);
        rc(MNSC_OFF_PC, 32'h802 + 32'h2 + 32'h7fe);
        rc(MNSC_OFF_TOP, 32'h804);
        rc(MNSC_OFF_DEPTH, 32'h3);
        rc(MNSC_OFF_STATUS, st);
    endtask

    task automatic finish_test();
        $display("Checks run %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Whole run needs a few hundred cycles; this cuts a hang short
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_negate();
        t_mul();
        t_idle();
        t_stack();
        t_call();
        finish_test();
    end
endmodule // mnsc_core_bench

bind mnsc_core mnsc_core_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .busy(busy));
`default_nettype wire
